// ==== common/fps_pkg.sv ====
/*
 fps_pkg: constants and carrier types for the fault protection sequencer.
 assumes a 100 MHz system clock; analog comparisons arrive as digital levels.
*/
package fps_pkg;
   localparam int CLK_MHZ          = 100;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int FAULT_TIME_MS    = 100;
   localparam int FAULT_CYCLES     = FAULT_TIME_MS * 1000 * CLK_MHZ;
   localparam int BLANK_TIME_NS    = 1000;
   localparam int BLANK_CYCLES     = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUAL_TIME_NS     = 600;
   localparam int QUAL_CYCLES      = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EVENTS_TO_LATCH  = 4;
   localparam int SOFT_START_CYCLES = 4096;
   localparam int CNT_W            = 24;
   localparam int BLK_W            = 8;
   localparam int EVT_W            = 3;
   localparam int SS_W             = 13;

   // supply monitor levels from the analog comparators
   typedef struct packed {
      logic wake_level;
      logic turn_on_level;
   } fps_supply_t;

   typedef enum logic [2:0] {
      FPS_RUN, FPS_STOPPED, FPS_WAKE, FPS_SOFT_START, FPS_LATCHED
   } fps_state_t;
endpackage

// ==== dv/fault_protection_sequencer_tb.sv ====
/*
 fault_protection_sequencer_tb: latch-off qualification and hiccup restart.
 assumes shortened FAULT_LIMIT and SS_LIMIT; switching period of 220 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_protection_sequencer_tb;
   import fps_pkg::*;
   localparam int FLIM = 50;
   localparam int SSL  = 16;
   localparam int PER  = 220;
   typedef struct { logic [7:0] st; logic [7:0] ln; int n; logic lat; } fps_row_t;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        pwm_en = 1'b0;
   logic        pwm_request = 1'b0;
   logic        overload_flag = 1'b0;
   fps_supply_t supply = '0;
   logic [7:0]  hi_start = 8'h00;
   logic [7:0]  hi_len = 8'h00;
   logic        cmp_high, gate_drive, ramp_connect, supply_pulldown;
   logic        latch_holding_element, soft_start_active, fault_timer_running, g;
   int          err_total = 0;
   int          checks_done = 0;
   int          ph = 0;
   // blanking spike, short high, three events, four or more events
   fps_row_t    rows [4] = '{'{8'h00, 8'h5F, 5, 1'b0}, '{8'h69, 8'h32, 5, 1'b0},
                             '{8'h66, 8'h50, 3, 1'b0}, '{8'h66, 8'h50, 6, 1'b1}};
   fps_sequencer #(.FAULT_LIMIT(FLIM), .SS_LIMIT(SSL)) dut (.clk(clk), .arst_n(arst_n),
      .pwm_request(pwm_request), .overload_flag(overload_flag), .supply(supply),
      .power_limit_protect_input(cmp_high), .gate_drive(gate_drive), .ramp_connect(ramp_connect),
      .supply_pulldown(supply_pulldown), .latch_holding_element(latch_holding_element),
      .soft_start_active(soft_start_active), .fault_timer_running(fault_timer_running));
   fps_aux_model aux (.clk(clk), .gate_drive(gate_drive), .hi_start(hi_start), .hi_len(hi_len),
      .cmp_high(cmp_high));
   always #5 clk = ~clk;
   always @(negedge clk) begin
      ph <= (ph == PER - 1) ? 0 : ph + 1;
      pwm_request <= pwm_en && (ph < 20);
      if (arst_n) check(ramp_connect, gate_drive);
   end
   task check(input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks=%0d mismatches=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task do_reset;
      @(negedge clk) arst_n = 1'b0;
      repeat (10) @(negedge clk);
      check(gate_drive, 1'b0);
      check(latch_holding_element, 1'b0);
      arst_n = 1'b1;
   endtask
   task wait_ss(input logic v);
      for (int i = 0; i < 5000 && soft_start_active !== v; i++) @(negedge clk);
      if (soft_start_active !== v) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, soft_start_active, v);
         final_report();
      end
   endtask
   // any gate pulse over one switching period
   task gate_seen;
      g = 1'b0;
      repeat (PER) begin
         @(negedge clk);
         g = g | gate_drive;
      end
   endtask
   task arm(input logic [7:0] s, input logic [7:0] l);
      hi_len = 8'h00;
      do_reset();
      wait_ss(1'b1);
      wait_ss(1'b0);
      repeat (PER) @(negedge clk);
      hi_start = s;
      hi_len = l;
   endtask
   initial begin
      pwm_en = 1'b1;
      foreach (rows[i]) begin
         arm(rows[i].st, rows[i].ln);
         repeat (rows[i].n * PER) @(negedge clk);
         check(latch_holding_element, rows[i].lat);
         check(supply_pulldown, rows[i].lat);
         $display("row %0d done", i);
      end
      // latched: supply restart and overload must not wake it
      supply = 2'b11;
      overload_flag = 1'b1;
      gate_seen();
      check(g, 1'b0);
      check(latch_holding_element, 1'b1);
      overload_flag = 1'b0;
      supply = '0;
      $display("latch hold done");
      // a quiet off-time between runs of three clears the count
      arm(8'h66, 8'h50);
      repeat (3 * PER) @(negedge clk);
      hi_len = 8'h00;
      repeat (PER) @(negedge clk);
      hi_len = 8'h50;
      repeat (3 * PER) @(negedge clk);
      check(latch_holding_element, 1'b0);
      repeat (3 * PER) @(negedge clk);
      check(latch_holding_element, 1'b1);
      $display("event clear done");
      // hiccup: stop, wake, restart with soft-start, then recover
      arm(8'h00, 8'h00);
      overload_flag = 1'b1;
      repeat (3) @(negedge clk);
      check(fault_timer_running, 1'b1);
      repeat (FLIM + 5) @(negedge clk);
      gate_seen();
      check(g, 1'b0);
      supply.wake_level = 1'b1;
      repeat (5) @(negedge clk);
      check(soft_start_active, 1'b0);
      supply.turn_on_level = 1'b1;
      wait_ss(1'b1);
      supply = '0;
      repeat (FLIM + SSL + 5) @(negedge clk);
      gate_seen();
      check(g, 1'b0);
      overload_flag = 1'b0;
      supply.wake_level = 1'b1;
      repeat (5) @(negedge clk);
      supply.turn_on_level = 1'b1;
      wait_ss(1'b1);
      wait_ss(1'b0);
      gate_seen();
      check(g, 1'b1);
      $display("hiccup done");
      final_report();
   end
endmodule
`default_nettype wire

// ==== dv/fps_aux_model.sv ====
/*
 fps_aux_model: comparator view of the auxiliary winding plateau.
 assumes gate_drive from the sequencer; the bench sets the high window.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_aux_model (
   // clock
   input  wire logic       clk,
   // gate and high window, in cycles after turn-off
   input  wire logic       gate_drive,
   input  wire logic [7:0] hi_start,
   input  wire logic [7:0] hi_len,
   // comparator level
   output logic            cmp_high
);
   logic [15:0] off_cnt_reg = 16'hFFFF;
   always_ff @(posedge clk) begin
      if (gate_drive) begin
         off_cnt_reg <= 16'h0000;
      end else if (off_cnt_reg != 16'hFFFF) begin
         off_cnt_reg <= off_cnt_reg + 16'h0001;
      end
   end
   // a start of zero models the leakage spike inside blanking
   assign cmp_high = !gate_drive && (off_cnt_reg >= {8'h00, hi_start})
                     && (off_cnt_reg < {8'h00, hi_start} + {8'h00, hi_len});
endmodule
`default_nettype wire

// ==== rtl/fps_ovp_qualifier.sv ====
/*
 fps_ovp_qualifier: blanking, width qualification and successive-event count
 on the protection comparator. assumes gate_on is the registered drive state.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_ovp_qualifier
   import fps_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // switching state and comparator
   input  wire logic gate_on,
   input  wire logic cmp_above,
   // result
   output logic      latch_req
);
   logic [BLK_W-1:0] blank_reg;
   logic [BLK_W-1:0] width_reg;
   logic [EVT_W-1:0] evt_reg;
   logic             seen_reg;
   logic             gate_d_reg;
   logic             turn_off;
   logic             turn_on;
   logic             window;
   logic             qualified;

   assign turn_off  = gate_d_reg & ~gate_on;
   assign turn_on   = ~gate_d_reg & gate_on;
   assign window    = ~gate_on & (blank_reg == BLK_W'(0)) & ~turn_off;
   assign qualified = window & cmp_above & (width_reg == BLK_W'(QUAL_CYCLES - 1)) & ~seen_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blank_reg  <= '0;
         width_reg  <= '0;
         evt_reg    <= '0;
         seen_reg   <= 1'b0;
         gate_d_reg <= 1'b0;
         latch_req  <= 1'b0;
      end else begin
         gate_d_reg <= gate_on;
         if (turn_off)
            blank_reg <= BLK_W'(BLANK_CYCLES);
         else if (blank_reg != BLK_W'(0))
            blank_reg <= blank_reg - BLK_W'(1);
         // width counter restarts on every low, so short highs vanish
         if (window & cmp_above & width_reg != BLK_W'(QUAL_CYCLES - 1))
            width_reg <= width_reg + BLK_W'(1);
         else if (!(window & cmp_above))
            width_reg <= '0;
         if (qualified) begin
            seen_reg <= 1'b1;
            evt_reg  <= evt_reg + EVT_W'(1);
         end
         // one evaluation per cycle: at next turn-on, no event means restart
         if (turn_on) begin
            seen_reg <= 1'b0;
            if (!seen_reg)
               evt_reg <= '0;
         end
         if (evt_reg == EVT_W'(EVENTS_TO_LATCH))
            latch_req <= 1'b1;
      end
   end

   a_event_needs_width: assert property (@(posedge clk) disable iff (!arst_n)
      qualified |-> $past(cmp_above, 1) && $past(window, 1)) else $error("event without width");
   a_blank_holds_off: assert property (@(posedge clk) disable iff (!arst_n)
      turn_off |=> !window [*8]) else $error("sampled during blanking");
   a_clear_on_miss: assert property (@(posedge clk) disable iff (!arst_n)
      (turn_on && !seen_reg) |=> evt_reg == '0) else $error("count not cleared");
   c_event: cover property (@(posedge clk) disable iff (!arst_n) qualified);
endmodule
`default_nettype wire

// ==== rtl/fps_sequencer.sv ====
/*
 fps_sequencer: overload timer, hiccup restart with soft-start, latch-off
 and compensation ramp gating. assumes pwm_request comes from the oscillator
 and peak comparator; supply levels come from the analog monitors.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer
   import fps_pkg::*;
#(
   parameter int FAULT_LIMIT = FAULT_CYCLES,
   parameter int SS_LIMIT    = SOFT_START_CYCLES
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // controller inputs
   input  wire logic        pwm_request,
   input  wire logic        overload_flag,
   input  wire fps_pkg::fps_supply_t supply,
   input  wire logic        power_limit_protect_input,
   // outputs
   output logic             gate_drive,
   output logic             ramp_connect,
   output logic             supply_pulldown,
   output logic             latch_holding_element,
   output logic             soft_start_active,
   output logic             fault_timer_running
);
   import fps_pkg::*;

   fps_state_t       state_reg;
   fps_state_t       state_next;
   logic [CNT_W-1:0] fault_cnt_reg;
   logic [SS_W-1:0]  ss_cnt_reg;
   logic             latch_req;
   logic             fault_expired;
   logic             ss_done;
   logic             drive_allowed;
   logic             gate_next;

   // latch decode shared by the pulldown and the holding element outputs
   function automatic logic fps_latched(input fps_state_t s);
      return s == FPS_LATCHED;
   endfunction

   fps_ovp_qualifier u_qual (
      .clk       (clk),
      .arst_n    (arst_n),
      .gate_on   (gate_drive),
      .cmp_above (power_limit_protect_input),
      .latch_req (latch_req)
   );

   assign fault_expired = fault_cnt_reg >= CNT_W'(FAULT_LIMIT);
   assign ss_done       = ss_cnt_reg >= SS_W'(SS_LIMIT);
   assign drive_allowed = (state_reg == FPS_RUN) | (state_reg == FPS_SOFT_START);
   // soft-start here blocks the gate on odd ss_cnt_reg counts, every other clock, until it completes
   assign gate_next     = drive_allowed & pwm_request & ~latch_req & ~fault_expired
                          & ~(soft_start_active & ss_cnt_reg[0]);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FPS_RUN:        if (fault_expired) state_next = FPS_STOPPED;
         FPS_STOPPED:    if (supply.wake_level) state_next = FPS_WAKE;
         FPS_WAKE:       if (supply.turn_on_level) state_next = FPS_SOFT_START;
         FPS_SOFT_START: begin
            if (fault_expired) state_next = FPS_STOPPED;
            else if (ss_done) state_next = FPS_RUN;
         end
         FPS_LATCHED:    state_next = FPS_LATCHED;
         default:        state_next = FPS_STOPPED;
      endcase
      if (latch_req)
         state_next = FPS_LATCHED;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= FPS_SOFT_START;
         fault_cnt_reg <= '0;
         ss_cnt_reg    <= '0;
      end else begin
         state_reg <= state_next;
         if (overload_flag & drive_allowed & ~fault_expired)
            fault_cnt_reg <= fault_cnt_reg + CNT_W'(1);
         else if (!overload_flag | state_next == FPS_WAKE)
            fault_cnt_reg <= '0;
         if (state_reg == FPS_WAKE)
            ss_cnt_reg <= '0;
         else if (state_reg == FPS_SOFT_START & ~ss_done)
            ss_cnt_reg <= ss_cnt_reg + SS_W'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_drive            <= 1'b0;
         ramp_connect          <= 1'b0;
         supply_pulldown       <= 1'b0;
         latch_holding_element <= 1'b0;
         soft_start_active     <= 1'b0;
         fault_timer_running   <= 1'b0;
      end else begin
         gate_drive            <= gate_next;
         ramp_connect          <= gate_next;
         supply_pulldown       <= fps_latched(state_next);
         latch_holding_element <= fps_latched(state_next);
         soft_start_active     <= state_next == FPS_SOFT_START;
         fault_timer_running   <= overload_flag & drive_allowed;
      end
   end

   a_ramp_on_time: assert property (@(posedge clk) disable iff (!arst_n)
      ramp_connect == gate_drive) else $error("ramp outside on-time");
   a_latch_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_LATCHED |=> state_reg == FPS_LATCHED && !gate_drive) else $error("latch released");
   a_latch_kills_gate: assert property (@(posedge clk) disable iff (!arst_n)
      latch_req |=> !gate_drive && supply_pulldown) else $error("gate after latch");
   a_timeout_stops: assert property (@(posedge clk) disable iff (!arst_n)
      fault_expired && drive_allowed && !latch_req |=> state_reg == FPS_STOPPED || state_reg == FPS_LATCHED)
      else $error("no stop");
   a_stopped_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_STOPPED |=> !gate_drive) else $error("drive while stopped");
   a_wake_then_soft: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_WAKE && supply.turn_on_level && !latch_req |=> state_reg == FPS_SOFT_START)
      else $error("no restart");
   a_soft_start_runs: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(state_reg == FPS_SOFT_START) |-> ss_cnt_reg == '0 && soft_start_active) else $error("soft-start skipped");
   a_latch_needs_evt: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(latch_req) |-> $past(u_qual.evt_reg, 1) == EVT_W'(EVENTS_TO_LATCH)) else $error("latched early");
   c_hiccup: cover property (@(posedge clk) disable iff (!arst_n) state_reg == FPS_STOPPED);
   c_restart: cover property (@(posedge clk) disable iff (!arst_n) $rose(state_reg == FPS_SOFT_START));
   c_latch: cover property (@(posedge clk) disable iff (!arst_n) $rose(latch_holding_element));
   c_recover: cover property (@(posedge clk) disable iff (!arst_n) $fell(soft_start_active));

   // drive only ever follows a request seen in a state that may switch
   a_gate_needs_req: assert property (@(posedge clk) disable iff (!arst_n)
      gate_drive |-> $past(pwm_request, 1) && $past(drive_allowed, 1))
      else $error("gate without request");
   a_timer_flag: assert property (@(posedge clk) disable iff (!arst_n)
      fault_timer_running |-> $past(overload_flag, 1))
      else $error("timer without overload");
   a_ramp_off_time: assert property (@(posedge clk) disable iff (!arst_n)
      !gate_drive |-> !ramp_connect)
      else $error("ramp during off-time");
   a_pulldown_pair: assert property (@(posedge clk) disable iff (!arst_n)
      supply_pulldown == latch_holding_element)
      else $error("latch outputs split");

   // hiccup sequence: each state waits for its own supply level
   a_stopped_holds: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_STOPPED && !supply.wake_level && !latch_req |=> state_reg == FPS_STOPPED)
      else $error("left stop early");
   a_stop_wakes: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_STOPPED && supply.wake_level && !latch_req |=> state_reg == FPS_WAKE)
      else $error("no wake");
   a_wake_waits: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_WAKE && !supply.turn_on_level && !latch_req |=> state_reg == FPS_WAKE)
      else $error("restart too early");
   a_wake_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_WAKE |=> !gate_drive)
      else $error("drive while waking");
   a_wake_timer_clear: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_WAKE |-> fault_cnt_reg == '0)
      else $error("timer kept over wake");

   // restart outcome: a lasting fault starts another hiccup, else normal run
   a_fault_rearm: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_SOFT_START && fault_expired && !latch_req |=> state_reg == FPS_STOPPED)
      else $error("no new hiccup");
   a_soft_ends_run: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_SOFT_START && ss_done && !fault_expired && !latch_req |=> state_reg == FPS_RUN)
      else $error("no recovery");
   a_run_holds: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_RUN && !fault_expired && !latch_req |=> state_reg == FPS_RUN)
      else $error("run left early");
   a_soft_thins: assert property (@(posedge clk) disable iff (!arst_n)
      soft_start_active && ss_cnt_reg[0] |=> !gate_drive)
      else $error("soft-start not limiting");

   // latch side: nothing may switch or start once the latch is taken
   a_req_latches: assert property (@(posedge clk) disable iff (!arst_n)
      latch_req |=> state_reg == FPS_LATCHED)
      else $error("latch request lost");
   a_latch_no_soft: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_LATCHED |-> !soft_start_active && supply_pulldown)
      else $error("soft-start while latched");
   a_latched_no_ramp: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == FPS_LATCHED |-> !ramp_connect)
      else $error("ramp while latched");
endmodule
`default_nettype wire
